// File: inc/usp_pkg.sv
// Shared constants and types of the asynchronous serial port
package usp_pkg;
  // Register byte offsets on the APB
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_BUF = 8'h04;
  localparam logic [7:0] OFS_PWR = 8'h08;
  localparam logic [7:0] OFS_BRG = 8'h0c;
  localparam logic [7:0] OFS_RELOAD = 8'h10;
  localparam logic [7:0] OFS_ADDR = 8'h14;
  localparam logic [7:0] OFS_MASK = 8'h18;
  // Bit positions in serial_ctrl
  localparam int B_FE = 7;
  localparam int B_SM0 = 7;
  localparam int B_SM1 = 6;
  localparam int B_MP = 5;
  localparam int B_REN = 4;
  localparam int B_TB8 = 3;
  localparam int B_RB8 = 2;
  localparam int B_TI = 1;
  localparam int B_RI = 0;
  // Bit positions in power_ctrl
  localparam int B_DBL = 7;
  localparam int B_FED = 6;
  // Bit positions in baud_gen_ctrl
  localparam int B_SPD = 0;
  localparam int B_RUN = 1;
  localparam int B_TXS = 2;
  localparam int B_RXS = 3;
  // Reset value of every register byte
  localparam logic [7:0] RST_BYTE = 8'h00;
  // Mode codes from mode_sel_hi, mode_sel_lo
  localparam logic [1:0] MODE_SYNC = 2'h0;
  localparam logic [1:0] MODE_8VAR = 2'h1;
  localparam logic [1:0] MODE_9FIX = 2'h2;
  localparam logic [1:0] MODE_9VAR = 2'h3;
  // Oversampling: sample points and last tick of a bit
  localparam logic [3:0] SAMP_A = 4'h7;
  localparam logic [3:0] SAMP_B = 4'h8;
  localparam logic [3:0] SAMP_C = 4'h9;
  localparam logic [3:0] TICK_LAST = 4'hf;
  // Last step of the divide-by-6 prescaler
  localparam logic [2:0] PRE_LAST = 3'h5;
  // Index of the stop bit in 10 and 11 bit frames
  localparam logic [3:0] STOP_IDX8 = 4'h9;
  localparam logic [3:0] STOP_IDX9 = 4'ha;
  // Baud configuration carried to the generators
  typedef struct packed {
    logic dbl;
    logic baud_speed_sel;
    logic run;
    logic [7:0] reload;
  } usp_baud_cfg_t;
  // Receiver states
  typedef enum logic [2:0] {
    RX_IDLE, RX_START, RX_DATA, RX_NINTH, RX_STOP
  } usp_rx_st_t;
endpackage

// File: src/usp_brg.sv
// Internal 8-bit auto-reload baud generator
`timescale 1ns/1ns
`default_nettype none
module usp_brg import usp_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire usp_baud_cfg_t cfg,
  output logic ovf
);
  // Prescaler, counter and overflow pulse
  typedef struct packed {
    logic [2:0] pre;
    logic [7:0] cnt;
    logic ovf;
  } usp_brg_st_t;
  usp_brg_st_t q, n;
  logic step; // Counter advances this cycle

  // Count up from baud_reload, reload on overflow
  always_comb begin
    n = q;
    n.ovf = 1'b0;
    step = cfg.baud_speed_sel || (q.pre == PRE_LAST);
    if (!cfg.run) begin // Stopped: hold at reload
      n.pre = '0;
      n.cnt = cfg.reload;
    end else begin
      n.pre = step ? 3'h0 : q.pre + 3'h1;
      if (step) begin
        if (q.cnt == 8'hff) begin // Overflow
          n.cnt = cfg.reload;
          n.ovf = 1'b1;
        end else begin
          n.cnt = q.cnt + 8'h1;
        end
      end
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end
  assign ovf = q.ovf;
endmodule // usp_brg
`default_nettype wire

// File: src/usp_tick.sv
// Sixteen-times oversampling tick for one direction
`timescale 1ns/1ns
`default_nettype none
module usp_tick import usp_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic mode2,
  input wire logic src_int,
  input wire logic brg_ovf,
  input wire logic t1_ovf,
  input wire logic dbl,
  output logic tick
);
  // Halving toggle and tick pulse
  typedef struct packed {
    logic half;
    logic tick;
  } usp_tick_st_t;
  usp_tick_st_t q, n;
  logic raw; // Undivided source pulse

  // Pick source, halve unless doubled
  always_comb begin
    n = q;
    raw = mode2 ? 1'b1 : (src_int ? brg_ovf : t1_ovf);
    n.tick = 1'b0;
    if (raw) begin
      if (dbl) begin
        n.tick = 1'b1;
      end else begin
        n.half = ~q.half;
        n.tick = q.half;
      end
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end
  assign tick = q.tick;
endmodule // usp_tick
`default_nettype wire

// File: src/usp_serial.sv
// Asynchronous serial port, modes 1 to 3, with APB registers
`timescale 1ns/1ns
`default_nettype none
module usp_serial import usp_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic timer1_ovf,
  input wire logic serial_in_pin,
  output logic serial_out_pin
);
  // Whole state of the port
  typedef struct packed {
    logic ready;
    logic err;
    logic [31:0] rdata;
    logic fe;
    logic sm0;
    logic sm1;
    logic mp;
    logic ren;
    logic tb8;
    logic rb8;
    logic ti;
    logic ri;
    logic dbl;
    logic fed;
    logic baud_speed_sel;
    logic run;
    logic txs;
    logic rxs;
    logic [7:0] reload;
    logic [7:0] addr;
    logic [7:0] mask;
    logic [7:0] rxbuf;
    logic txon;
    logic [10:0] txsh;
    logic [3:0] txbit;
    logic [3:0] txcnt;
    logic txo;
    usp_rx_st_t rst;
    logic [3:0] rcnt;
    logic [2:0] rbit;
    logic [7:0] rsh;
    logic s7;
    logic s8;
    logic bitv;
    logic ninth;
    logic pin_q;
  } usp_st_t;
  usp_st_t q, n;

  logic [1:0] mode; // Selected mode
  logic async; // Any asynchronous mode
  logic nine; // Nine data bits per frame
  logic setup; // APB setup phase
  logic wr; // APB write access phase
  logic wr_ctrl; // Write to serial_ctrl
  logic wr_buf; // Write to serial_buffer
  logic mapped; // Address hits a register
  logic rtick; // Receive oversampling tick
  logic ttick; // Transmit oversampling tick
  logic brg_ovf; // Internal generator overflow
  logic fall; // Falling edge on the input line
  logic maj; // Majority of three samples
  logic [3:0] stop_idx; // Stop bit index of frame
  logic n9; // Ninth bit used for acceptance
  logic fin; // Frame completes this cycle
  logic match; // Address frame is for us
  usp_baud_cfg_t bcfg; // Generator configuration

  // Mode decode and bus qualifiers
  always_comb begin
    mode = {q.sm0, q.sm1};
    async = (mode != MODE_SYNC);
    nine = (mode == MODE_9FIX) || (mode == MODE_9VAR);
    setup = psel && !penable;
    wr = psel && penable && pwrite;
    wr_ctrl = wr && (paddr == OFS_CTRL);
    wr_buf = wr && (paddr == OFS_BUF);
    fall = q.pin_q && !serial_in_pin;
    bcfg = '{dbl: q.dbl, baud_speed_sel: q.baud_speed_sel, run: q.run, reload: q.reload};
  end

  // Internal baud generator
  usp_brg u_brg (
    .pclk(pclk),
    .presetn(presetn),
    .cfg(bcfg),
    .ovf(brg_ovf)
  );

  // Receive tick, own source select
  usp_tick u_rtick (
    .pclk(pclk),
    .presetn(presetn),
    .mode2(mode == MODE_9FIX),
    .src_int(q.rxs),
    .brg_ovf(brg_ovf),
    .t1_ovf(timer1_ovf),
    .dbl(q.dbl),
    .tick(rtick)
  );

  // Transmit tick, own source select
  usp_tick u_ttick (
    .pclk(pclk),
    .presetn(presetn),
    .mode2(mode == MODE_9FIX),
    .src_int(q.txs),
    .brg_ovf(brg_ovf),
    .t1_ovf(timer1_ovf),
    .dbl(q.dbl),
    .tick(ttick)
  );

  // Next state: bus, transmitter, receiver
  always_comb begin
    n = q;
    maj = 1'b0;
    n9 = 1'b0;
    fin = 1'b0;
    // Given address or broadcast address hit
    match = (((q.rsh ^ q.addr) & q.mask) == 8'h00) ||
            ((q.rsh | ~(q.addr | q.mask)) == 8'hff);
    stop_idx = nine ? STOP_IDX9 : STOP_IDX8;
    mapped = (paddr == OFS_CTRL) || (paddr == OFS_BUF) ||
             (paddr == OFS_PWR) || (paddr == OFS_BRG) ||
             (paddr == OFS_RELOAD) || (paddr == OFS_ADDR) ||
             (paddr == OFS_MASK);
    // Zero wait states; error for unmapped
    n.ready = 1'b1;
    if (setup) begin
      n.err = !mapped;
      n.rdata = '0;
      unique case (paddr)
        OFS_CTRL: n.rdata[7:0] = {q.fed ? q.fe : q.sm0, q.sm1, q.mp,
                                 q.ren, q.tb8, q.rb8, q.ti, q.ri};
        OFS_BUF: n.rdata[7:0] = q.rxbuf;
        OFS_PWR: n.rdata[7:0] = {q.dbl, q.fed, 6'h00};
        OFS_BRG: n.rdata[7:0] = {4'h0, q.rxs, q.txs, q.run, q.baud_speed_sel};
        OFS_RELOAD: n.rdata[7:0] = q.reload;
        OFS_ADDR: n.rdata[7:0] = q.addr;
        OFS_MASK: n.rdata[7:0] = q.mask;
        default: n.rdata = '0;
      endcase
    end
    // Register writes
    if (wr) begin
      unique case (paddr)
        OFS_CTRL: begin
          // Top bit is the error flag when detection is on
          if (q.fed) begin
            n.fe = pwdata[B_FE];
          end else begin
            n.sm0 = pwdata[B_SM0];
          end
          n.sm1 = pwdata[B_SM1];
          n.mp = pwdata[B_MP];
          n.ren = pwdata[B_REN];
          n.tb8 = pwdata[B_TB8];
          n.rb8 = pwdata[B_RB8];
          n.ti = pwdata[B_TI];
          n.ri = pwdata[B_RI];
        end
        OFS_PWR: begin
          n.dbl = pwdata[B_DBL];
          n.fed = pwdata[B_FED];
        end
        OFS_BRG: begin
          n.baud_speed_sel = pwdata[B_SPD];
          n.run = pwdata[B_RUN];
          n.txs = pwdata[B_TXS];
          n.rxs = pwdata[B_RXS];
        end
        OFS_RELOAD: n.reload = pwdata[7:0];
        OFS_ADDR: n.addr = pwdata[7:0];
        OFS_MASK: n.mask = pwdata[7:0];
        default: n.reload = q.reload;
      endcase
    end

    // Transmitter: load frame on a buffer write
    if (wr_buf && async) begin
      // Stop, ninth or stop, data, start; LSB first
      n.txsh = {1'b1, nine ? q.tb8 : 1'b1, pwdata[7:0], 1'b0};
      n.txon = 1'b1;
      n.txbit = 4'h0;
      n.txcnt = 4'h0;
    end else if (q.txon && ttick) begin
      n.txcnt = q.txcnt + 4'h1;
      // Bit time over: move to next bit
      if (q.txcnt == TICK_LAST) begin
        n.txsh = {1'b1, q.txsh[10:1]};
        n.txbit = q.txbit + 4'h1;
        // Last data bit sent: transmit done
        if (q.txbit + 4'h1 == stop_idx) begin
          n.ti = 1'b1;
        end
        // Stop bit sent: frame over
        if (q.txbit == stop_idx) begin
          n.txon = 1'b0;
        end
      end
    end
    // Line idles high
    n.txo = n.txon ? n.txsh[0] : 1'b1;

    // Receiver: previous line level for edges
    n.pin_q = serial_in_pin;
    if (q.rst == RX_IDLE) begin
      // Start on falling edge when enabled
      if (q.ren && async && fall) begin
        n.rst = RX_START;
        n.rcnt = 4'h0;
      end
    end else if (rtick) begin
      n.rcnt = q.rcnt + 4'h1;
      // Keep the first two centre samples
      if (q.rcnt == SAMP_A) begin
        n.s7 = serial_in_pin;
      end
      if (q.rcnt == SAMP_B) begin
        n.s8 = serial_in_pin;
      end
      // Decide at the third centre sample
      if (q.rcnt == SAMP_C) begin
        maj = (q.s7 & q.s8) | (q.s7 & serial_in_pin) |
              (q.s8 & serial_in_pin);
        n.bitv = maj;
        unique case (q.rst)
          // False start: line not still low
          RX_START: if (maj) n.rst = RX_IDLE;
          // Data shifts in LSB first
          RX_DATA: n.rsh = {maj, q.rsh[7:1]};
          RX_NINTH: begin
            n.ninth = maj;
            // Without detection done at the ninth bit
            if (!q.fed) begin
              fin = 1'b1;
              n9 = maj;
            end
          end
          RX_STOP: begin
            // Stop bit must be high when checked
            if (q.fed && !maj) begin
              n.fe = 1'b1;
            end
            // With detection, done at stop bit
            if (q.fed || !nine) begin
              fin = 1'b1;
              n9 = nine ? q.ninth : maj;
            end
            n.rst = RX_IDLE;
          end
          default: n.rst = RX_IDLE;
        endcase
      end
      // End of a bit time: step to next bit
      if (q.rcnt == TICK_LAST) begin
        unique case (q.rst)
          RX_START: begin
            n.rst = RX_DATA;
            n.rbit = 3'h0;
          end
          RX_DATA: begin
            n.rbit = q.rbit + 3'h1;
            // After eight data bits
            if (q.rbit == 3'h7) begin
              n.rst = nine ? RX_NINTH : RX_STOP;
            end
          end
          RX_NINTH: n.rst = RX_STOP;
          default: n.rst = q.rst;
        endcase
      end
    end
    // Accept unless filtered as foreign or data
    if (fin && (!q.mp || (n9 && match))) begin
      n.rxbuf = q.rsh;
      n.rb8 = n9;
      n.ri = 1'b1;
    end
  end

  // State register; line and flags idle safe
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
      q.txo <= 1'b1;
      q.pin_q <= 1'b1;
    end else begin
      q <= n;
    end
  end

  // Outputs straight from flip-flops
  assign prdata = q.rdata;
  assign pready = q.ready;
  assign pslverr = q.err;
  assign serial_out_pin = q.txo;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // Buffer write drives start bit next cycle
  property p_tx_start;
    wr_buf && async |=> !serial_out_pin;
  endproperty
  a_tx_start: assert property (p_tx_start)
    else $error("start bit not sent after buffer write");

  // Idle transmitter holds line high
  property p_tx_idle;
    !q.txon |-> serial_out_pin;
  endproperty
  a_tx_idle: assert property (p_tx_idle)
    else $error("line not high while idle");

  // Error flag holds without a control write
  property p_fe_sticky;
    q.fe && !wr_ctrl |=> q.fe;
  endproperty
  a_fe_sticky: assert property (p_fe_sticky)
    else $error("frame error flag lost");

  // Hardware error only with detection on
  property p_fe_enabled;
    $rose(q.fe) && !$past(wr_ctrl) |-> $past(q.fed);
  endproperty
  a_fe_enabled: assert property (p_fe_enabled)
    else $error("frame error without detection");

  // Receive done only at ninth or stop bit
  property p_ri_point;
    $rose(q.ri) && !$past(wr_ctrl) |->
      $past(q.rst) == RX_STOP || $past(q.rst) == RX_NINTH;
  endproperty
  a_ri_point: assert property (p_ri_point)
    else $error("receive done at wrong bit");

  // Filtered receive only for ninth bit set
  property p_mp_addr;
    $rose(q.ri) && !$past(wr_ctrl) && $past(q.mp) |-> q.rb8;
  endproperty
  a_mp_addr: assert property (p_mp_addr)
    else $error("data frame accepted while filtering");

  // Transmit done when stop bit begins
  property p_ti_stop;
    $rose(q.ti) && !$past(wr_ctrl) |-> serial_out_pin && q.txon;
  endproperty
  a_ti_stop: assert property (p_ti_stop)
    else $error("transmit done not at stop bit");

  // Mode 2 undoubled: ticks never back to back
  property p_mode2_half;
    mode == MODE_9FIX && !q.dbl && rtick |=> !rtick;
  endproperty
  a_mode2_half: assert property (p_mode2_half)
    else $error("mode 2 rate not halved");

  // Disabled receiver stays idle
  property p_rx_off;
    q.rst == RX_IDLE && !q.ren |=> q.rst == RX_IDLE;
  endproperty
  a_rx_off: assert property (p_rx_off)
    else $error("receiver started while disabled");
endmodule // usp_serial
`default_nettype wire

// File: verification/usp_remote_node.sv
// Remote serial node on the line side of the serial port
`timescale 1ns/1ns
`default_nettype none
module usp_remote_node (
  input wire logic pclk,
  output logic line_to_dut,
  input wire logic line_from_dut
);
  // Last frame seen on the port's transmit line
  logic [10:0] bits;
  logic [7:0] got_data;
  logic got_ninth;
  logic got_stop;
  // Idle line is high from time zero
  initial begin
    line_to_dut = 1'b1;
  end
  // Send one frame, LSB first, cyc clocks per bit
  task automatic send(input logic [7:0] d, input logic ninth,
    input logic nine, input logic stop, input int cyc);
    logic [10:0] f;
    int nb;
    f = nine ? {stop, ninth, d, 1'b0} : {1'b0, stop, d, 1'b0};
    nb = nine ? 11 : 10;
    @(posedge pclk);
    for (int i = 0; i < nb; i++) begin
      line_to_dut <= f[i];
      repeat (cyc) @(posedge pclk);
    end
    // Back to idle, also after a bad stop bit
    line_to_dut <= 1'b1;
    repeat (4) @(posedge pclk);
  endtask
  // Capture one frame, sampling each bit in its middle
  task automatic grab(input int nb, input int cyc);
    @(negedge line_from_dut);
    repeat (cyc / 2) @(posedge pclk);
    for (int i = 0; i < nb; i++) begin
      bits[i] = line_from_dut;
      if (i < nb - 1) repeat (cyc) @(posedge pclk);
    end
    got_data = bits[8:1];
    got_ninth = bits[9];
    got_stop = bits[nb - 1];
  endtask
endmodule // usp_remote_node
`default_nettype wire

// File: verification/test_usp_serial.sv
// Self-checking bench of the asynchronous serial port
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin fails++; \
  $display("unexpected at %0t: got %h want %h", $time, g, e); end end
module test_usp_serial import usp_pkg::*;;
  // Bus and line signals
  logic pclk, presetn, psel, penable, pwrite, timer1_ovf, t1_run;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic pready, pslverr, rerr;
  wire serial_in_pin;
  wire serial_out_pin;
  int fails, num_checks;
  usp_serial i_usp_serial (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timer1_ovf(timer1_ovf), .serial_in_pin(serial_in_pin),
    .serial_out_pin(serial_out_pin));
  usp_remote_node i_usp_remote_node (.pclk(pclk),
    .line_to_dut(serial_in_pin), .line_from_dut(serial_out_pin));
  // 25 MHz clock
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  // Timer 1 overflow every second clock when enabled
  always @(posedge pclk) timer1_ovf <= t1_run ? ~timer1_ovf : 1'b0;
  // One APB transfer; read data kept in rdat and rerr
  task automatic apb(input logic wr, input logic [7:0] a,
    input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // Wait for the slave; only the hang guard ends a stuck wait
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Reset values and an unmapped address
  task t_reset();
    apb(1'b0, OFS_CTRL, 8'h00);
    `CHK(rdat, 32'h0)
    apb(1'b0, 8'h1c, 8'h00);
    `CHK(rerr, 1'b1)
    `CHK(rdat, 32'h0)
  endtask
  // Mode 2 transmit at clock/16 with ninth bit set
  task t_mode2_tx();
    apb(1'b1, OFS_PWR, 8'h80);
    apb(1'b1, OFS_CTRL, 8'h98);
    fork
      i_usp_remote_node.grab(11, 16);
      apb(1'b1, OFS_BUF, 8'ha5);
    join
    `CHK(i_usp_remote_node.got_data, 8'ha5)
    `CHK(i_usp_remote_node.got_ninth, 1'b1)
    `CHK(i_usp_remote_node.got_stop, 1'b1)
    apb(1'b0, OFS_CTRL, 8'h00);
    `CHK(rdat[B_TI], 1'b1)
  endtask
  // Mode 2 receive at clock/32
  task t_mode2_rx();
    apb(1'b1, OFS_PWR, 8'h00);
    apb(1'b1, OFS_CTRL, 8'h90);
    i_usp_remote_node.send(8'h3c, 1'b0, 1'b1, 1'b1, 32);
    apb(1'b0, OFS_BUF, 8'h00);
    `CHK(rdat, 32'h3c)
    apb(1'b0, OFS_CTRL, 8'h00);
    `CHK(rdat[B_RI], 1'b1)
    `CHK(rdat[B_RB8], 1'b0)
  endtask
  // Bad stop bit, then a good frame, then software clear
  task t_frame_err();
    apb(1'b1, OFS_CTRL, 8'h90);
    apb(1'b1, OFS_PWR, 8'h40);
    i_usp_remote_node.send(8'h11, 1'b1, 1'b1, 1'b0, 32);
    apb(1'b0, OFS_CTRL, 8'h00);
    `CHK(rdat[B_FE], 1'b1)
    i_usp_remote_node.send(8'h22, 1'b1, 1'b1, 1'b1, 32);
    apb(1'b0, OFS_CTRL, 8'h00);
    `CHK(rdat[B_FE], 1'b1)
    `CHK(rdat[B_RB8], 1'b1)
    apb(1'b1, OFS_CTRL, 8'h10);
    apb(1'b0, OFS_CTRL, 8'h00);
    `CHK(rdat[B_FE], 1'b0)
    apb(1'b1, OFS_PWR, 8'h00);
  endtask
  // Address filtering with a mask, then data after addressing
  task t_multiproc();
    apb(1'b1, OFS_PWR, 8'h80);
    apb(1'b1, OFS_ADDR, 8'h56);
    apb(1'b1, OFS_MASK, 8'hfc);
    apb(1'b1, OFS_CTRL, 8'hb0);
    i_usp_remote_node.send(8'h56, 1'b0, 1'b1, 1'b1, 16);
    apb(1'b0, OFS_CTRL, 8'h00);
    `CHK(rdat[B_RI], 1'b0)
    i_usp_remote_node.send(8'h55, 1'b1, 1'b1, 1'b1, 16);
    apb(1'b0, OFS_CTRL, 8'h00);
    `CHK(rdat[B_RI], 1'b1)
    `CHK(rdat[B_RB8], 1'b1)
    apb(1'b1, OFS_CTRL, 8'hb0);
    i_usp_remote_node.send(8'h66, 1'b1, 1'b1, 1'b1, 16);
    apb(1'b0, OFS_CTRL, 8'h00);
    `CHK(rdat[B_RI], 1'b0)
    apb(1'b1, OFS_CTRL, 8'h90);
    i_usp_remote_node.send(8'h77, 1'b0, 1'b1, 1'b1, 16);
    apb(1'b0, OFS_BUF, 8'h00);
    `CHK(rdat, 32'h77)
  endtask
  // Mode 1 full duplex, tx from generator, rx from timer 1
  task t_mode1_duplex();
    t1_run <= 1'b1;
    apb(1'b1, OFS_RELOAD, 8'hff);
    apb(1'b1, OFS_BRG, 8'h07);
    apb(1'b1, OFS_CTRL, 8'h50);
    fork
      i_usp_remote_node.grab(10, 16);
      apb(1'b1, OFS_BUF, 8'h5a);
      i_usp_remote_node.send(8'hc3, 1'b0, 1'b0, 1'b1, 32);
    join
    `CHK(i_usp_remote_node.got_data, 8'h5a)
    `CHK(i_usp_remote_node.got_stop, 1'b1)
    apb(1'b0, OFS_BUF, 8'h00);
    `CHK(rdat, 32'hc3)
    apb(1'b0, OFS_CTRL, 8'h00);
    `CHK(rdat[B_RB8], 1'b1)
  endtask
  // Counts and verdict, then stop
  task test_done();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    fails = 0;
    num_checks = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    t1_run = 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_mode2_tx();
    t_mode2_rx();
    t_frame_err();
    t_multiproc();
    t_mode1_duplex();
    test_done();
  end
  // Hang guard
  initial begin
    repeat (30000) @(posedge pclk);
    fails++;
    test_done();
  end
endmodule // test_usp_serial
`default_nettype wire
